// ==== hdl/mstseq_pkg.sv ====
// Package with the shared constants and types of the multi-segment trigger sequencer.
package mstseq_pkg;

   // Register byte offsets on the AXI4-Lite slave.
   localparam logic [7:0] MSTSEQ_CTRL_OFS    = 8'h00;
   localparam logic [7:0] MSTSEQ_SEGIDX_OFS  = 8'h04;
   localparam logic [7:0] MSTSEQ_GAP_OFS     = 8'h08;
   localparam logic [7:0] MSTSEQ_STATUS_OFS  = 8'h0c;
   localparam logic [7:0] MSTSEQ_SEGLEN_OFS  = 8'h10;
   localparam logic [7:0] MSTSEQ_LIST_OFS    = 8'h20;

   // Control register field positions.
   localparam int MSTSEQ_CTRL_MODE_LSB   = 0;
   localparam int MSTSEQ_CTRL_POLICY_LSB = 4;
   localparam int MSTSEQ_CTRL_EXT_BIT    = 8;
   localparam int MSTSEQ_CTRL_RATEEQ_BIT = 9;
   localparam int MSTSEQ_CTRL_LISTN_LSB  = 12;

   // Segment storage.
   localparam int MSTSEQ_NSEG    = 4;
   localparam int MSTSEQ_SEGW    = 2;
   localparam int MSTSEQ_SAMPW   = 16;
   localparam int MSTSEQ_ADDRW   = 8;
   localparam int MSTSEQ_NLIST   = 4;
   localparam int MSTSEQ_REPW    = 4;

   // Reset values.
   localparam logic [31:0] MSTSEQ_CTRL_RST   = 32'h0000_0000;
   localparam logic [15:0] MSTSEQ_GAP_RST    = 16'h0004;
   localparam logic [7:0]  MSTSEQ_SEGLEN_RST = 8'h10;
   localparam logic [MSTSEQ_REPW-1:0] MSTSEQ_REP_RST = 4'h1;

   typedef enum logic [2:0]
   {
      MSTSEQ_FREE_RUN,
      MSTSEQ_ARM_THEN_LOOP,
      MSTSEQ_ONE_SHOT,
      MSTSEQ_RESTARTABLE_LOOP,
      MSTSEQ_ARM_THEN_RESTARTABLE
   } mstseq_mode_t;

   typedef enum logic [1:0]
   {
      MSTSEQ_POL_NEXT_SEGMENT,
      MSTSEQ_POL_ADVANCE_AT_END,
      MSTSEQ_POL_PLAY_LIST
   } mstseq_policy_t;

   typedef enum logic [1:0]
   {
      MSTSEQ_ST_IDLE,
      MSTSEQ_ST_GAP,
      MSTSEQ_ST_PLAY
   } mstseq_state_t;

endpackage : mstseq_pkg

// ==== hdl/mstseq_edge.sv ====
// Rising edge detector for one trigger input.
`timescale 1ns/1ns
module mstseq_edge
(
   // Clock and reset.
   input  wire logic aclk,
   input  wire logic aresetn,
   // Level in, pulse out.
   input  wire logic level_in,
   output logic      pulse_out
);

   logic prev_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         prev_r <= 1'b0;
      else
         prev_r <= level_in;
   end

   // A held level makes one pulse only.
   assign pulse_out = level_in & ~prev_r;

endmodule : mstseq_edge

// ==== hdl/mstseq_skid.sv ====
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ns
module mstseq_skid
#(
   parameter int WIDTH = 16
)
(
   // Clock and reset.
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // Filling side.
   input  wire logic             s_valid,
   output logic                  s_ready,
   input  wire logic [WIDTH-1:0] s_data,
   // Draining side.
   output logic                  m_valid,
   input  wire logic             m_ready,
   output logic [WIDTH-1:0]      m_data
);

   logic [WIDTH-1:0] mem_r [2];
   logic             wp_r;
   logic             rp_r;
   logic [1:0]       cnt_r;
   logic             push;
   logic             pop;

   assign s_ready = (cnt_r != 2'd2);
   assign m_valid = (cnt_r != 2'd0);
   assign m_data  = mem_r[rp_r];
   assign push    = s_valid & s_ready;
   assign pop     = m_valid & m_ready;

   always_ff @(posedge aclk)
   begin
      if (push)
         mem_r[wp_r] <= s_data;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wp_r  <= 1'b0;
         rp_r  <= 1'b0;
         cnt_r <= 2'd0;
      end
      else
      begin
         if (push)
            wp_r <= ~wp_r;
         if (pop)
            rp_r <= ~rp_r;
         cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      end
   end

endmodule : mstseq_skid

// ==== hdl/mstseq_top.sv ====
// Multi-segment trigger sequencer with AXI4-Lite registers and a buffered sample stream.
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
module mstseq_top
   import mstseq_pkg::*;
(
   // Clock and reset.
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   // AXI4-Lite write address and data.
   input  wire logic [7:0]              s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0]                   s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   // AXI4-Lite read.
   input  wire logic [7:0]              s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic [31:0]                  s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready,
   // Trigger inputs.
   input  wire logic                    trig_in,
   input  wire logic                    next_trig_in,
   // Sample stream out.
   output logic                         m_valid,
   input  wire logic                    m_ready,
   output logic [MSTSEQ_SAMPW-1:0]      m_data
);

   logic [31:0]             ctrl_r;
   logic [MSTSEQ_SEGW-1:0]  segidx_r;
   logic                    idx_wr_r;
   logic [15:0]             gap_r;
   logic [7:0]              seglen_r [MSTSEQ_NSEG];
   logic [MSTSEQ_SEGW-1:0]  list_seg_r [MSTSEQ_NLIST];
   logic [MSTSEQ_REPW-1:0]  list_rep_r [MSTSEQ_NLIST];
   logic                    reject_r;
   logic                    aw_hold_r;
   logic                    w_hold_r;
   logic [7:0]              aw_addr_r;
   logic [31:0]             w_data_r;
   logic [3:0]              w_strb_r;

   mstseq_state_t           state_r;
   logic [MSTSEQ_SEGW-1:0]  cur_r;
   logic [MSTSEQ_SEGW-1:0]  next_seg_r;
   logic [MSTSEQ_ADDRW-1:0] addr_r;
   logic [15:0]             gap_cnt_r;
   logic [1:0]              lptr_r;
   logic [MSTSEQ_REPW-1:0]  rep_r;
   logic                    pend_next_r;
   logic                    pend_idx_r;

   logic                    trig_p;
   logic                    next_p;
   logic                    do_write;
   logic                    fill_ready;
   logic                    play_valid;
   logic [MSTSEQ_SAMPW-1:0] play_data;
   logic                    seg_last;

   mstseq_mode_t            mode;
   mstseq_policy_t          policy;
   logic                    ext_src;
   logic                    arm_mode;
   logic                    restart_mode;
   logic [1:0]              list_n;

   assign mode         = mstseq_mode_t'(ctrl_r[MSTSEQ_CTRL_MODE_LSB +: 3]);
   assign policy       = mstseq_policy_t'(ctrl_r[MSTSEQ_CTRL_POLICY_LSB +: 2]);
   assign ext_src      = ctrl_r[MSTSEQ_CTRL_EXT_BIT];
   assign list_n       = ctrl_r[MSTSEQ_CTRL_LISTN_LSB +: 2];
   assign arm_mode     = (mode == MSTSEQ_ARM_THEN_LOOP) || (mode == MSTSEQ_ARM_THEN_RESTARTABLE) ||
                         (mode == MSTSEQ_ONE_SHOT);
   assign restart_mode = (mode == MSTSEQ_RESTARTABLE_LOOP) || (mode == MSTSEQ_ARM_THEN_RESTARTABLE) ||
                         (mode == MSTSEQ_ONE_SHOT);

   mstseq_edge u_trig_edge
   (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .level_in  (trig_in),
      .pulse_out (trig_p)
   );

   mstseq_edge u_next_edge
   (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .level_in  (next_trig_in),
      .pulse_out (next_p)
   );

   // Write address and data are caught separately so either may come first.
   assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_hold_r & ~s_axi_bvalid;
   assign do_write      = aw_hold_r & w_hold_r;
   assign s_axi_bresp   = 2'b00;
   assign s_axi_rresp   = 2'b00;
   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_r    <= 1'b0;
         w_hold_r     <= 1'b0;
         aw_addr_r    <= 8'h00;
         w_data_r     <= 32'h0000_0000;
         w_strb_r     <= 4'h0;
         s_axi_bvalid <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_hold_r    <= 1'b0;
            w_hold_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Register stores; strobes are honoured per lane on the wide control word.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_r   <= MSTSEQ_CTRL_RST;
         segidx_r <= '0;
         idx_wr_r <= 1'b0;
         gap_r    <= MSTSEQ_GAP_RST;
         reject_r <= 1'b0;
         for (int i = 0; i < MSTSEQ_NSEG; i++)
            seglen_r[i] <= MSTSEQ_SEGLEN_RST;
         for (int i = 0; i < MSTSEQ_NLIST; i++)
         begin
            list_seg_r[i] <= MSTSEQ_SEGW'(i);
            list_rep_r[i] <= MSTSEQ_REP_RST;
         end
      end
      else
      begin
         idx_wr_r <= 1'b0;
         if (do_write)
         begin
            if (aw_addr_r == MSTSEQ_CTRL_OFS)
            begin
               // Seamless advance needs one rate for all segments; else the whole control word keeps its old value.
               if (w_data_r[MSTSEQ_CTRL_POLICY_LSB +: 2] == 2'(MSTSEQ_POL_ADVANCE_AT_END) &&
                   !w_data_r[MSTSEQ_CTRL_RATEEQ_BIT])
                  reject_r <= 1'b1;
               else
               begin
                  reject_r <= 1'b0;
                  for (int b = 0; b < 4; b++)
                     if (w_strb_r[b])
                        ctrl_r[8*b +: 8] <= w_data_r[8*b +: 8];
               end
            end
            if (aw_addr_r == MSTSEQ_SEGIDX_OFS && w_strb_r[0])
            begin
               segidx_r <= w_data_r[MSTSEQ_SEGW-1:0];
               idx_wr_r <= 1'b1;
            end
            if (aw_addr_r == MSTSEQ_GAP_OFS && w_strb_r[0])
               gap_r <= w_data_r[15:0];
            for (int i = 0; i < MSTSEQ_NSEG; i++)
               if (aw_addr_r == MSTSEQ_SEGLEN_OFS + 8'(4*i) && w_strb_r[0])
                  seglen_r[i] <= w_data_r[7:0];
            for (int i = 0; i < MSTSEQ_NLIST; i++)
               if (aw_addr_r == MSTSEQ_LIST_OFS + 8'(4*i) && w_strb_r[0])
               begin
                  list_seg_r[i] <= w_data_r[MSTSEQ_SEGW-1:0];
                  list_rep_r[i] <= w_data_r[4 +: MSTSEQ_REPW];
               end
         end
      end
   end

   // Read side; unmapped addresses read as zero with OKAY.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= 32'h0000_0000;
         case (s_axi_araddr)
            MSTSEQ_CTRL_OFS:   s_axi_rdata <= ctrl_r;
            MSTSEQ_SEGIDX_OFS: s_axi_rdata <= {30'h0, segidx_r};
            MSTSEQ_GAP_OFS:    s_axi_rdata <= {16'h0, gap_r};
            MSTSEQ_STATUS_OFS: s_axi_rdata <= {17'h0, reject_r, 2'(state_r), 2'b00, cur_r, addr_r};
            default:
            begin
               for (int i = 0; i < MSTSEQ_NSEG; i++)
                  if (s_axi_araddr == MSTSEQ_SEGLEN_OFS + 8'(4*i))
                     s_axi_rdata <= {24'h0, seglen_r[i]};
               for (int i = 0; i < MSTSEQ_NLIST; i++)
                  if (s_axi_araddr == MSTSEQ_LIST_OFS + 8'(4*i))
                     s_axi_rdata <= {24'h0, list_rep_r[i], 2'b00, list_seg_r[i]};
            end
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // The sample source is a stand-in ramp tagged by segment; a real memory would drop in here.
   assign seg_last   = (addr_r == seglen_r[cur_r] - 8'd1);
   assign play_valid = (state_r != MSTSEQ_ST_IDLE);
   assign play_data  = (state_r == MSTSEQ_ST_PLAY) ? {6'h00, cur_r, addr_r} : '0;

   // Playback sequencer; sample steps stall while the buffer cannot accept a sample, but triggers and index writes act at once.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_r     <= MSTSEQ_ST_IDLE;
         cur_r       <= '0;
         next_seg_r  <= '0;
         addr_r      <= '0;
         gap_cnt_r   <= '0;
         lptr_r      <= 2'd0;
         rep_r       <= '0;
         pend_next_r <= 1'b0;
         pend_idx_r  <= 1'b0;
      end
      else
      begin
         if (next_p && policy == MSTSEQ_POL_ADVANCE_AT_END)
            pend_next_r <= 1'b1;
         if (idx_wr_r && policy == MSTSEQ_POL_ADVANCE_AT_END)
            pend_idx_r <= 1'b1;
         // A one_shot index change only stores the choice; blocking the step below would repeat a sample.
         if (idx_wr_r && policy == MSTSEQ_POL_NEXT_SEGMENT && mode == MSTSEQ_ONE_SHOT)
            next_seg_r <= segidx_r;
         if (idx_wr_r && policy == MSTSEQ_POL_NEXT_SEGMENT && mode != MSTSEQ_ONE_SHOT)
         begin
            if (ext_src && mode == MSTSEQ_ARM_THEN_LOOP)
            begin
               next_seg_r <= segidx_r;
               state_r    <= MSTSEQ_ST_IDLE;
            end
            else
            begin
               cur_r     <= segidx_r;
               addr_r    <= '0;
               gap_cnt_r <= gap_r;
               state_r   <= MSTSEQ_ST_GAP;
            end
         end
         else if (ext_src && next_p && policy == MSTSEQ_POL_NEXT_SEGMENT &&
                  (state_r != MSTSEQ_ST_IDLE || mode == MSTSEQ_ONE_SHOT))
         begin
            // Segment count is a power of two, so the increment wraps to the first.
            cur_r     <= cur_r + MSTSEQ_SEGW'(1);
            addr_r    <= '0;
            gap_cnt_r <= gap_r;
            state_r   <= (mode == MSTSEQ_ONE_SHOT) ? MSTSEQ_ST_PLAY : MSTSEQ_ST_GAP;
         end
         else if (trig_p && (state_r == MSTSEQ_ST_IDLE || restart_mode) &&
                  !(ext_src && policy == MSTSEQ_POL_NEXT_SEGMENT && !restart_mode && state_r != MSTSEQ_ST_IDLE))
         begin
            if (state_r == MSTSEQ_ST_IDLE || mode == MSTSEQ_ONE_SHOT)
               cur_r <= (policy == MSTSEQ_POL_PLAY_LIST) ? list_seg_r[0] : next_seg_r;
            if (policy == MSTSEQ_POL_PLAY_LIST)
            begin
               lptr_r <= 2'd0;
               rep_r  <= '0;
            end
            addr_r  <= '0;
            state_r <= MSTSEQ_ST_PLAY;
         end
         else if (fill_ready)
         begin
            case (state_r)
               MSTSEQ_ST_IDLE:
               begin
                  if (!arm_mode)
                  begin
                     state_r <= MSTSEQ_ST_PLAY;
                     if (policy == MSTSEQ_POL_PLAY_LIST)
                        cur_r <= list_seg_r[0];
                  end
               end
               MSTSEQ_ST_GAP:
               begin
                  if (gap_cnt_r <= 16'd1)
                     state_r <= MSTSEQ_ST_PLAY;
                  gap_cnt_r <= gap_cnt_r - 16'd1;
               end
               MSTSEQ_ST_PLAY:
               begin
                  addr_r <= seg_last ? '0 : addr_r + 8'd1;
                  if (seg_last)
                  begin
                     if (mode == MSTSEQ_ONE_SHOT)
                        state_r <= MSTSEQ_ST_IDLE;
                     if (policy == MSTSEQ_POL_ADVANCE_AT_END)
                     begin
                        if (pend_idx_r && mode != MSTSEQ_ARM_THEN_LOOP)
                        begin
                           cur_r      <= segidx_r;
                           pend_idx_r <= 1'b0;
                        end
                        else if (pend_next_r)
                           cur_r <= cur_r + MSTSEQ_SEGW'(1);
                        // A trigger landing on the last sample stays pending for the next end.
                        pend_next_r <= next_p;
                     end
                     else if (policy == MSTSEQ_POL_PLAY_LIST)
                     begin
                        if (rep_r + 4'd1 >= list_rep_r[lptr_r])
                        begin
                           rep_r  <= '0;
                           lptr_r <= (lptr_r >= list_n) ? 2'd0 : lptr_r + 2'd1;
                           cur_r  <= list_seg_r[(lptr_r >= list_n) ? 2'd0 : lptr_r + 2'd1];
                        end
                        else
                           rep_r <= rep_r + 4'd1;
                     end
                  end
               end
               default: state_r <= MSTSEQ_ST_IDLE;
            endcase
         end
      end
   end

   mstseq_skid #(.WIDTH(MSTSEQ_SAMPW)) u_buf
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .s_valid (play_valid),
      .s_ready (fill_ready),
      .s_data  (play_data),
      .m_valid (m_valid),
      .m_ready (m_ready),
      .m_data  (m_data)
   );

endmodule : mstseq_top

// ==== verification/mstseq_checker.sv ====
// Concurrent checks on the bus and stream ports of the sequencer.
`timescale 1ns/1ns
module mstseq_checker
(
   // Clock and reset.
   input wire logic        aclk,
   input wire logic        aresetn,
   // Register bus.
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Sample stream.
   input wire logic        m_valid,
   input wire logic        m_ready,
   input wire logic [15:0] m_data
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   AST_WR_ANSWER: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
      else $error("write answer missing");
   AST_RD_ANSWER: assert property (rd_taken |=> s_axi_rvalid)
      else $error("read answer missing");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && s_axi_bresp == 2'h0)
      else $error("write answer dropped");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer changed");
   AST_RRESP_OK: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0)
      else $error("read response not okay");
   AST_AR_BLOCK: assert property (s_axi_arready == !s_axi_rvalid)
      else $error("read address ready wrong");
   AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during answer");
   AST_M_HOLD: assert property (m_valid && !m_ready |=> m_valid && $stable(m_data))
      else $error("stream word lost under stall");
   AST_M_FORMAT: assert property (m_valid |-> m_data[15:10] == 6'h00)
      else $error("stream word has stray bits");
endmodule : mstseq_checker

bind mstseq_top mstseq_checker u_chk (.*);

// ==== verification/mstseq_far.sv ====
// Far side model: external trigger source and stream sink.
`timescale 1ns/1ns
module mstseq_far
(
   // Clock and sink speed.
   input wire logic aclk,
   input wire logic slow,
   // Trigger lines and sink ready.
   output logic     trig_in,
   output logic     next_trig_in,
   output logic     m_ready
);
   logic [1:0] cnt_r;
   initial
   begin
      trig_in = 1'b0;
      next_trig_in = 1'b0;
      cnt_r = 2'h0;
      m_ready = 1'b1;
   end
   // A slow sink refuses one word in four so the buffer sees stalls.
   always @(posedge aclk)
   begin
      cnt_r <= cnt_r + 2'h1;
      m_ready <= !slow || cnt_r != 2'h0;
   end
   task pulse(input logic nxt);
      @(posedge aclk);
      next_trig_in <= nxt;
      trig_in <= !nxt;
      repeat (2) @(posedge aclk);
      next_trig_in <= 1'b0;
      trig_in <= 1'b0;
   endtask : pulse
endmodule : mstseq_far

// ==== verification/tb_top.sv ====
// Self-checking testbench of the multi-segment trigger sequencer.
`timescale 1ns/1ns
module tb_top;
   import mstseq_pkg::*;
   logic aclk, aresetn, slow, trig_in, next_trig_in, m_valid, m_ready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [15:0] m_data, w;
   logic [15:0] q [$];
   int fails, cmp_count;
   mstseq_top dut (.*);
   mstseq_far u_far (.*);
   initial
   begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   // Every accepted word is queued so no word slips by while a task is busy.
   always @(posedge aclk)
      if (m_valid && m_ready)
         q.push_back(m_data);
   task summarize();
      if (fails == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : summarize
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (s_axi_awvalid || s_axi_wvalid);
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      s_axi_rready <= 1'b0;
   endtask : rd
   task getw();
      while (q.size() == 0) @(posedge aclk);
      w = q.pop_front();
   endtask : getw
   task gc(input logic [15:0] e);
      getw();
      chk(w, e);
   endtask : gc
   task sync(input logic [15:0] e);
      do getw(); while (w !== e);
   endtask : sync
   // Finds the switch to segment s and counts the zero words before its first sample.
   task sw(input logic [1:0] s, input int g);
      logic [15:0] p;
      int z, zl;
      z = 0;
      zl = 0;
      p = 16'hffff;
      getw();
      while (w !== {6'h00, s, 8'h01})
      begin
         zl = (w === 16'h0000) ? zl : z;
         z = (w === 16'h0000) ? z + 1 : 0;
         p = w;
         getw();
      end
      chk(p, {6'h00, s, 8'h00});
      chk(s == 2'd0 ? z : zl, g + (s == 2'd0));
   endtask : sw
   task quiet();
      int n;
      n = 0;
      repeat (40) @(posedge aclk) n += (m_valid !== 1'b0);
      chk(n, 0);
   endtask : quiet
   task t_regs();
      logic [31:0] d;
      logic [7:0] ra [5] = '{MSTSEQ_CTRL_OFS, MSTSEQ_GAP_OFS, MSTSEQ_SEGLEN_OFS, MSTSEQ_LIST_OFS + 8'h04, 8'h40};
      logic [31:0] rv [5] = '{MSTSEQ_CTRL_RST, {16'h0, MSTSEQ_GAP_RST}, {24'h0, MSTSEQ_SEGLEN_RST}, 32'h11, 32'h0};
      for (int i = 0; i < 5; i++)
      begin
         rd(ra[i], d);
         chk(d, rv[i]);
      end
      wr(MSTSEQ_CTRL_OFS, 32'h10);
      rd(MSTSEQ_CTRL_OFS, d);
      chk(d, 32'h0);
      rd(MSTSEQ_STATUS_OFS, d);
      chk(d[14], 1'b1);
      s_axi_wstrb <= 4'h2;
      wr(MSTSEQ_CTRL_OFS, 32'h0000_0103);
      s_axi_wstrb <= 4'hf;
      rd(MSTSEQ_CTRL_OFS, d);
      chk(d, 32'h100);
      wr(MSTSEQ_CTRL_OFS, 32'h0);
   endtask : t_regs
   task t_free();
      wr(MSTSEQ_GAP_OFS, 32'h3);
      for (int i = 1; i < 4; i++)
         wr(MSTSEQ_SEGLEN_OFS + 8'(4 * i), 32'h5);
      wr(MSTSEQ_SEGIDX_OFS, 32'h1);
      sync(16'h0101);
      for (int i = 2; i < 7; i++)
         gc({8'h01, 8'(i % 5)});
      slow <= 1'b1;
      wr(MSTSEQ_SEGIDX_OFS, 32'h2);
      sw(2'd2, 3);
      slow <= 1'b0;
   endtask : t_free
   task t_ext();
      logic [7:0] p;
      wr(MSTSEQ_CTRL_OFS, 32'h100);
      u_far.pulse(1'b0);
      q.delete();
      getw();
      p = w[7:0];
      for (int i = 0; i < 10; i++)
      begin
         gc({8'h02, 8'((p + 8'h1) % 5)});
         p = w[7:0];
      end
      u_far.pulse(1'b1);
      sw(2'd3, 3);
      u_far.pulse(1'b1);
      sw(2'd0, 3);
      u_far.pulse(1'b1);
      sw(2'd1, 3);
   endtask : t_ext
   task t_seam();
      logic [31:0] d;
      wr(MSTSEQ_CTRL_OFS, 32'h210);
      rd(MSTSEQ_CTRL_OFS, d);
      chk(d, 32'h210);
      wr(MSTSEQ_SEGIDX_OFS, 32'h2);
      sw(2'd2, 0);
      u_far.pulse(1'b1);
      sw(2'd3, 0);
   endtask : t_seam
   task t_once();
      wr(MSTSEQ_CTRL_OFS, 32'h102);
      wr(MSTSEQ_SEGIDX_OFS, 32'h3);
      u_far.pulse(1'b0);
      repeat (60) @(posedge aclk);
      q.delete();
      quiet();
      u_far.pulse(1'b0);
      for (int i = 0; i < 5; i++)
         gc({8'h03, 8'(i)});
      quiet();
      u_far.pulse(1'b1);
      gc(16'h0000);
      gc(16'h0001);
      wr(MSTSEQ_SEGIDX_OFS, 32'h1);
      for (int i = 2; i < 16; i++)
         gc({8'h00, 8'(i)});
      u_far.pulse(1'b0);
      for (int i = 0; i < 5; i++)
         gc({8'h01, 8'(i)});
      quiet();
   endtask : t_once
   // A halted arm mode waits for a trigger; restart modes jump back to the first sample.
   task t_arm();
      int n;
      wr(MSTSEQ_SEGLEN_OFS + 8'h0c, 32'h40);
      wr(MSTSEQ_CTRL_OFS, 32'h101);
      wr(MSTSEQ_SEGIDX_OFS, 32'h2);
      u_far.pulse(1'b0);
      for (int i = 0; i < 7; i++)
         gc({8'h02, 8'(i % 5)});
      wr(MSTSEQ_SEGIDX_OFS, 32'h3);
      repeat (5) @(posedge aclk);
      q.delete();
      quiet();
      wr(MSTSEQ_CTRL_OFS, 32'h4);
      quiet();
      u_far.pulse(1'b0);
      gc(16'h0300);
      for (int m = 4; m > 2; m--)
      begin
         wr(MSTSEQ_CTRL_OFS, 32'(m));
         repeat (8) @(posedge aclk);
         u_far.pulse(1'b0);
         q.delete();
         n = 0;
         do
         begin
            getw();
            n++;
         end
         while (w !== 16'h0300 && n < 9);
         chk(n < 6, 1'b1);
      end
   endtask : t_arm
   task t_list();
      logic [15:0] pl [6] = '{16'h0300, 16'h0301, 16'h0300, 16'h0301, 16'h0100, 16'h0101};
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      wr(MSTSEQ_LIST_OFS, 32'h23);
      wr(MSTSEQ_LIST_OFS + 8'h04, 32'h11);
      wr(MSTSEQ_SEGLEN_OFS + 8'h04, 32'h2);
      wr(MSTSEQ_SEGLEN_OFS + 8'h0c, 32'h2);
      wr(MSTSEQ_CTRL_OFS, 32'h1020);
      q.delete();
      sync(16'h0101);
      for (int i = 0; i < 12; i++)
         gc(pl[i % 6]);
   endtask : t_list
   initial
   begin
      #2000000;
      fails++;
      summarize();
   end
   initial
   begin
      {aresetn, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      fails = 0;
      cmp_count = 0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_free();
      t_ext();
      t_seam();
      t_once();
      t_arm();
      t_list();
      summarize();
   end
endmodule : tb_top
